// >>> core/hst_ctrl.sv
// Controller that issues only legal cross-bank commands to the memory pins
// Operation
// - Activate another bank while one is busy
// - Precharge all needs every bank prechargeable
// - Burst stop only during running burst
// - Burst stop aimed only at burst bank
// - Refresh, self refresh, mode write: all idle
// - Only NOP during mode read/write busy
// - Wait act_to_act_delay between activates
// - Write only after read burst ends
// - Read only after write burst ends
// - Auto close bursts honour precharge timing
// - Reset from power-on, all banks idle
// - Unlisted combinations are refused
// - Commands only with clock gate high twice
// - Mask pin high drops its byte of the data beat
`timescale 1ns/1ps
`default_nettype none
module hst_ctrl import hst_pkg::*; #(
  parameter int INIT_CYC = ns2cyc(INIT_NS) // Initialization length in cycles
) (
  input wire logic clock, // System clock, 50 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire logic req_valid, // Request present
  input wire hst_cmd_t req_cmd, // Requested command
  input wire logic [BANK_W-1:0] req_bank, // Addressed bank
  input wire logic req_all, // Precharge targets all banks
  input wire logic req_auto_close, // Read/write closes the row
  input wire logic [DQ_W-1:0] req_wdata, // Write data
  input wire logic [DM_W-1:0] req_wmask, // Per-byte mask, high drops
  input wire logic sleep_req, // Ask for power-down / stay in self refresh
  output logic req_ready, // Request taken this cycle
  output logic req_reject, // Request refused as illegal
  output logic [DQ_W-1:0] rd_data, // Read data
  output logic rd_valid, // Read data valid pulse
  output logic mem_ck, // Link clock out
  output logic mem_cke, // Clock gate pin
  output hst_cmd_t mem_cmd, // Command pins
  output logic [BANK_W-1:0] mem_bank, // Bank pins
  output logic mem_all, // All-bank / reset flag pin
  output logic mem_auto_close, // Auto close pin
  output logic [DQ_W-1:0] mem_dq_o, // Data out
  output logic mem_dq_oe, // Data output enable, high drives
  input wire logic [DQ_W-1:0] mem_dq_i, // Data in from pins
  output logic [DM_W-1:0] write_mask_pin // Write mask pins
);
  logic [2:0] div_r, div_nxt;
  logic ck_r, ck_nxt;
  hst_phase_t ph_r, ph_nxt;
  logic [INIT_W-1:0] ph_cnt_r, ph_cnt_nxt;
  logic [TMR_W-1:0] rrd_r, rrd_nxt, exit_r, exit_nxt, bcnt_r, bcnt_nxt;
  logic bon_r, bon_nxt, brd_r, brd_nxt, burst_end, burst_over;
  logic [BANK_W-1:0] bbank_r, bbank_nxt;
  logic cke_r, cke_nxt, ckep_r, ckep_nxt, sref_r, sref_nxt;
  logic [DQ_W-1:0] dq_s1_r, dq_s2_r, wdata_r, wdata_nxt, rdat_r, rdat_nxt;
  logic [DM_W-1:0] wmask_r, wmask_nxt;
  logic rdv_r, rdv_nxt;
  hst_cmd_t pcmd_r, pcmd_nxt;
  logic [BANK_W-1:0] pbank_r, pbank_nxt;
  logic pall_r, pall_nxt, pac_r, pac_nxt;
  hst_bank_st_t burst_stop_cmd [NBANK];
  logic [NBANK-1:0] hit;
  logic slot, legal, take, all_idle, any_busy, pre_all_ok, mrr_ok, cmd_ok, bcast;
  hst_bank_st_t tgt;

  assign slot = (div_r == DIV_ISSUE);
  assign tgt = burst_stop_cmd[req_bank];
  assign take = req_valid && req_ready;
  assign burst_end = bon_r && (bcnt_r == TMR_ONE);
  // A new burst or a stop also closes the running one, else its bank would stay busy forever
  assign burst_over = bon_r && (burst_end || (take && req_cmd inside {C_RD, C_WR, C_BST}));

  // Per-bank state records
  for (genvar i = 0; i < NBANK; i++) begin : g_bank
    hst_bank u_bank (
      .clock(clock),
      .resetn(resetn),
      .hit(hit[i]),
      .cmd(req_cmd),
      .auto_close(req_auto_close),
      .burst_end(burst_over && (bbank_r == BANK_W'(i))),
      .state(burst_stop_cmd[i])
    );
  end

  // Summaries over all banks
  always_comb begin
    all_idle = 1'b1;
    any_busy = 1'b0;
    pre_all_ok = !bon_r;
    mrr_ok = !bon_r;
    bcast = (req_cmd inside {C_MRR, C_MRW, C_RST, C_REF, C_SREF}) || (req_cmd == C_PRE && req_all);
    for (int i = 0; i < NBANK; i++) begin
      all_idle = all_idle && (burst_stop_cmd[i] == B_IDLE);
      any_busy = any_busy || (burst_stop_cmd[i] inside {B_REFRESHING, B_MRR_IDLE, B_MRR_ACT, B_MRW});
      pre_all_ok = pre_all_ok && (burst_stop_cmd[i] inside {B_IDLE, B_ACTIVE});
      mrr_ok = mrr_ok && (burst_stop_cmd[i] inside {B_IDLE, B_ACTIVATING, B_ACTIVE, B_PRECHARGING});
      hit[i] = take && (bcast || req_bank == BANK_W'(i));
    end
  end

  // Legality of the offered command; anything not listed is refused
  always_comb begin
    cmd_ok = cke_r && ckep_r && (exit_r == TMR_ZERO);
    legal = 1'b0;
    case (ph_r)
      PH_POWER_ON: legal = (req_cmd == C_RST) && all_idle && !bon_r;
      PH_RESETTING: legal = (req_cmd == C_MRR);
      PH_RUN: begin
        if (!any_busy) begin
          case (req_cmd)
            C_ACT: legal = (tgt == B_IDLE) && (rrd_r == TMR_ZERO);
            C_RD: legal = (tgt inside {B_ACTIVE, B_READING, B_WRITING}) &&
                          !(bon_r && !brd_r);
            C_WR: legal = (tgt inside {B_ACTIVE, B_READING, B_WRITING}) &&
                          !(bon_r && brd_r);
            C_PRE: legal = req_all ? pre_all_ok : (tgt inside {B_IDLE, B_ACTIVE});
            C_BST: legal = bon_r && (bbank_r == req_bank) &&
                           (tgt inside {B_READING, B_WRITING}); // No stop on auto close bursts
            C_REF, C_SREF, C_MRW: legal = all_idle && !bon_r;
            C_MRR: legal = mrr_ok;
            default: legal = 1'b0;
          endcase
        end
      end
      default: legal = 1'b0;
    endcase
    legal = legal && cmd_ok;
    if (req_cmd == C_NOP) legal = 1'b1;
    req_ready = slot && legal;
    req_reject = slot && req_valid && !legal;
  end

  // Link clock divider, device phase, activate spacing and clock gate
  always_comb begin
    div_nxt = div_r + 3'h1;
    ck_nxt = (div_nxt >= DIV_CK_HI);
    ph_nxt = ph_r;
    ph_cnt_nxt = (ph_cnt_r != '0) ? ph_cnt_r - 1'b1 : ph_cnt_r;
    rrd_nxt = (rrd_r != TMR_ZERO) ? rrd_r - TMR_ONE : rrd_r;
    exit_nxt = (exit_r != TMR_ZERO) ? exit_r - TMR_ONE : exit_r;
    cke_nxt = cke_r;
    sref_nxt = sref_r;
    ckep_nxt = slot ? cke_r : ckep_r; // Gate level at previous link edge
    if (take && req_cmd == C_ACT) rrd_nxt = RRD_CYC;
    case (ph_r)
      PH_POWER_ON: if (take && req_cmd == C_RST) begin
        ph_nxt = PH_RESETTING;
        ph_cnt_nxt = INIT_W'(INIT_CYC);
      end
      PH_RESETTING: begin
        if (take && req_cmd == C_MRR) begin
          ph_nxt = PH_RST_MRR;
          ph_cnt_nxt = INIT_W'(MRR_CYC);
        end else if (ph_cnt_r == INIT_W'(1)) begin
          ph_nxt = PH_RUN;
        end
      end
      PH_RST_MRR: if (ph_cnt_r == INIT_W'(1)) ph_nxt = PH_RUN;
      default: ph_nxt = PH_RUN;
    endcase
    // Power-down entry only at a slot with no command; self refresh drops the gate at the same slot that takes C_SREF
    if (take && req_cmd == C_SREF) begin
      cke_nxt = 1'b0;
      sref_nxt = 1'b1;
    end else if (slot && !cke_r && !sleep_req) begin
      cke_nxt = 1'b1;
      sref_nxt = 1'b0;
      exit_nxt = sref_r ? SRX_CYC : PDX_CYC;
    end else if (slot && cke_r && sleep_req && !take && ph_r == PH_RUN && all_idle &&
                 !bon_r && exit_r == TMR_ZERO) begin
      cke_nxt = 1'b0;
    end
  end

  // Burst tracking, write data, read capture and pin drive
  always_comb begin
    bon_nxt = bon_r;
    brd_nxt = brd_r;
    bbank_nxt = bbank_r;
    bcnt_nxt = (bcnt_r != TMR_ZERO) ? bcnt_r - TMR_ONE : bcnt_r;
    wdata_nxt = wdata_r;
    wmask_nxt = wmask_r;
    rdat_nxt = rdat_r;
    rdv_nxt = 1'b0;
    pcmd_nxt = pcmd_r;
    pbank_nxt = pbank_r;
    pall_nxt = pall_r;
    pac_nxt = pac_r;
    if (burst_end) begin
      bon_nxt = 1'b0;
      rdv_nxt = brd_r;
      rdat_nxt = brd_r ? dq_s2_r : rdat_r;
    end
    if (take && (req_cmd == C_RD || req_cmd == C_WR)) begin
      bon_nxt = 1'b1;
      brd_nxt = (req_cmd == C_RD);
      bbank_nxt = req_bank;
      bcnt_nxt = BURST_CYC;
      if (req_cmd == C_WR) begin
        wdata_nxt = req_wdata;
        wmask_nxt = req_wmask;
      end
    end else if (take && req_cmd == C_BST) begin
      bon_nxt = 1'b0;
    end
    // Pins change only at the slot so they are stable at the link rising edge
    if (slot) begin
      pcmd_nxt = take ? ((req_cmd == C_RST) ? C_MRW : req_cmd) : C_NOP;
      pbank_nxt = req_bank;
      pall_nxt = take && (req_all || req_cmd == C_RST);
      pac_nxt = take && req_auto_close;
    end
  end

  // Registers for all groups; data pins are synchronised through two stages
  always_ff @(posedge clock) begin
    dq_s1_r <= mem_dq_i;
    dq_s2_r <= dq_s1_r;
    if (!resetn) begin
      div_r <= 3'h0;
      ck_r <= 1'b0;
      ph_r <= PH_POWER_ON;
      ph_cnt_r <= '0;
      rrd_r <= TMR_ZERO;
      exit_r <= TMR_ZERO;
      cke_r <= 1'b1;
      ckep_r <= 1'b1;
      sref_r <= 1'b0;
      bon_r <= 1'b0;
      brd_r <= 1'b0;
      bbank_r <= '0;
      bcnt_r <= TMR_ZERO;
      wdata_r <= '0;
      wmask_r <= '0;
      rdat_r <= '0;
      rdv_r <= 1'b0;
      pcmd_r <= C_NOP;
      pbank_r <= '0;
      pall_r <= 1'b0;
      pac_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      ck_r <= ck_nxt;
      ph_r <= ph_nxt;
      ph_cnt_r <= ph_cnt_nxt;
      rrd_r <= rrd_nxt;
      exit_r <= exit_nxt;
      cke_r <= cke_nxt;
      ckep_r <= ckep_nxt;
      sref_r <= sref_nxt;
      bon_r <= bon_nxt;
      brd_r <= brd_nxt;
      bbank_r <= bbank_nxt;
      bcnt_r <= bcnt_nxt;
      wdata_r <= wdata_nxt;
      wmask_r <= wmask_nxt;
      rdat_r <= rdat_nxt;
      rdv_r <= rdv_nxt;
      pcmd_r <= pcmd_nxt;
      pbank_r <= pbank_nxt;
      pall_r <= pall_nxt;
      pac_r <= pac_nxt;
    end
  end

  assign mem_ck = ck_r;
  assign mem_cke = cke_r;
  assign mem_cmd = pcmd_r;
  assign mem_bank = pbank_r;
  assign mem_all = pall_r;
  assign mem_auto_close = pac_r;
  assign mem_dq_o = wdata_r;
  assign mem_dq_oe = bon_r && !brd_r;
  assign write_mask_pin = wmask_r;
  assign rd_data = rdat_r;
  assign rd_valid = rdv_r;

  // Checks on what the controller issues
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_act_spacing: assert property (take && req_cmd == C_ACT |-> rrd_r == TMR_ZERO)
    else $error("activate issued before spacing elapsed");
  a_bst_target: assert property (take && req_cmd == C_BST |-> bon_r && bbank_r == req_bank)
    else $error("burst stop without matching burst");
  a_bst_ends: assert property (take && req_cmd == C_BST |=> !bon_r && !mem_dq_oe)
    else $error("burst stop did not end burst");
  a_all_idle: assert property (take && req_cmd inside {C_REF, C_SREF, C_MRW} |-> all_idle)
    else $error("refresh or mode write with busy bank");
  a_busy_nop: assert property (ph_r == PH_RUN && any_busy |-> !(take && req_cmd != C_NOP))
    else $error("command issued during busy state");
  a_wr_after_rd: assert property (take && req_cmd == C_WR |-> !(bon_r && brd_r))
    else $error("write interrupts read burst");
  a_rd_after_wr: assert property (take && req_cmd == C_RD |-> !(bon_r && !brd_r))
    else $error("read interrupts write burst");
  a_gate_high: assert property (take && req_cmd != C_NOP |->
    cke_r && ckep_r && exit_r == TMR_ZERO)
    else $error("command with clock gate not settled");
  a_mask_drive: assert property (take && req_cmd == C_WR |=>
    mem_dq_oe && write_mask_pin == $past(req_wmask))
    else $error("write mask not driven with data");
  a_pre_all: assert property (take && req_cmd == C_PRE && req_all |-> pre_all_ok)
    else $error("precharge all with bank not ready");
  a_reset_start: assert property (take && req_cmd == C_RST |=>
    ph_r == PH_RESETTING ##[1:8] mem_cmd == C_MRW && mem_all)
    else $error("reset not sent as mode write");
  c_act: cover property (take && req_cmd == C_ACT);
  c_bst: cover property (take && req_cmd == C_BST);
  c_init_done: cover property (ph_r == PH_RESETTING ##1 ph_r == PH_RUN);
  c_wake: cover property (!cke_r ##1 cke_r);
endmodule
`default_nettype wire

// >>> core/hst_pkg.sv
// Package: constants, timing and types for the bank legality controller
package hst_pkg;
  localparam int CLK_MHZ = 50;
  localparam int NBANK = 8;
  localparam int BANK_W = 3;
  localparam int DQ_W = 16;
  localparam int DM_W = 2;
  localparam int TMR_W = 8;
  localparam int INIT_W = 16;
  // Link clock divider: 8 system cycles per link clock period
  localparam logic [2:0] DIV_ISSUE = 3'h0;
  localparam logic [2:0] DIV_CK_HI = 3'h4;
  // Times in ns (plain defaults; the device's figures are not given)
  localparam int ACT_TO_ACT_NS = 10;
  localparam int ROW_TO_COL_NS = 18;
  localparam int ROW_CLOSE_NS = 18;
  localparam int REFRESH_NS = 130;
  localparam int MODE_READ_NS = 40;
  localparam int MODE_WRITE_NS = 50;
  localparam int BURST_NS = 320;
  localparam int PD_EXIT_NS = 100;
  localparam int SR_EXIT_NS = 140;
  localparam int INIT_NS = 200000;
  // Least time rounded up to whole cycles, never below one
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam logic [TMR_W-1:0] RRD_CYC = TMR_W'(ns2cyc(ACT_TO_ACT_NS));
  localparam logic [TMR_W-1:0] RCD_CYC = TMR_W'(ns2cyc(ROW_TO_COL_NS));
  localparam logic [TMR_W-1:0] RP_CYC = TMR_W'(ns2cyc(ROW_CLOSE_NS));
  localparam logic [TMR_W-1:0] RFC_CYC = TMR_W'(ns2cyc(REFRESH_NS));
  localparam logic [TMR_W-1:0] MRR_CYC = TMR_W'(ns2cyc(MODE_READ_NS));
  localparam logic [TMR_W-1:0] MRW_CYC = TMR_W'(ns2cyc(MODE_WRITE_NS));
  localparam logic [TMR_W-1:0] BURST_CYC = TMR_W'(ns2cyc(BURST_NS));
  localparam logic [TMR_W-1:0] PDX_CYC = TMR_W'(ns2cyc(PD_EXIT_NS));
  localparam logic [TMR_W-1:0] SRX_CYC = TMR_W'(ns2cyc(SR_EXIT_NS));
  localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;
  localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;
  typedef enum logic [3:0] {
    C_NOP, C_ACT, C_RD, C_WR, C_PRE, C_BST, C_REF, C_SREF, C_MRR, C_MRW, C_RST
  } hst_cmd_t;
  typedef enum logic [3:0] {
    B_IDLE, B_ACTIVATING, B_ACTIVE, B_READING, B_WRITING, B_RD_AC, B_WR_AC,
    B_PRECHARGING, B_REFRESHING, B_MRR_IDLE, B_MRR_ACT, B_MRW
  } hst_bank_st_t;
  typedef enum logic [1:0] {PH_POWER_ON, PH_RESETTING, PH_RST_MRR, PH_RUN} hst_phase_t;
endpackage

// >>> core/hst_bank.sv
// One bank's state record with its own state timer
`timescale 1ns/1ps
`default_nettype none
module hst_bank import hst_pkg::*; (
  input wire logic clock, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic hit, // Command taken for this bank
  input wire hst_cmd_t cmd, // Command being taken
  input wire logic auto_close, // Close row when burst ends
  input wire logic burst_end, // Burst of this bank ran out
  output var hst_bank_st_t state // Current bank state
);
  hst_bank_st_t st_r, st_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  logic done;

  assign done = (tmr_r <= TMR_ONE);
  assign state = st_r;

  // Next state; timed states end when their timer runs down
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = (tmr_r != TMR_ZERO) ? tmr_r - TMR_ONE : tmr_r;
    case (st_r)
      B_IDLE: begin
        if (hit && cmd == C_ACT) begin
          st_nxt = B_ACTIVATING;
          tmr_nxt = RCD_CYC;
        end else if (hit && cmd == C_PRE) begin
          st_nxt = B_PRECHARGING; // Row close time applies even when idle
          tmr_nxt = RP_CYC;
        end else if (hit && cmd == C_REF) begin
          st_nxt = B_REFRESHING;
          tmr_nxt = RFC_CYC;
        end else if (hit && cmd == C_MRR) begin
          st_nxt = B_MRR_IDLE;
          tmr_nxt = MRR_CYC;
        end else if (hit && (cmd == C_MRW || cmd == C_RST)) begin
          st_nxt = B_MRW;
          tmr_nxt = MRW_CYC;
        end
      end
      B_ACTIVATING: begin
        if (hit && cmd == C_MRR) begin
          st_nxt = B_MRR_ACT;
          tmr_nxt = MRR_CYC;
        end else if (done) begin
          st_nxt = B_ACTIVE;
        end
      end
      B_ACTIVE, B_READING, B_WRITING: begin
        if (hit && (cmd == C_RD || cmd == C_WR)) begin
          if (cmd == C_RD) st_nxt = auto_close ? B_RD_AC : B_READING;
          else st_nxt = auto_close ? B_WR_AC : B_WRITING;
        end else if (hit && cmd == C_PRE) begin
          st_nxt = B_PRECHARGING;
          tmr_nxt = RP_CYC;
        end else if (hit && cmd == C_MRR && st_r == B_ACTIVE) begin
          st_nxt = B_MRR_ACT;
          tmr_nxt = MRR_CYC;
        end else if ((hit && cmd == C_BST) || burst_end) begin
          st_nxt = B_ACTIVE;
        end
      end
      B_RD_AC, B_WR_AC: begin
        if (burst_end) begin
          st_nxt = B_PRECHARGING;
          tmr_nxt = RP_CYC;
        end
      end
      B_PRECHARGING: begin
        if (hit && cmd == C_MRR) begin
          st_nxt = B_MRR_IDLE;
          tmr_nxt = MRR_CYC;
        end else if (done) begin
          st_nxt = B_IDLE;
        end
      end
      B_REFRESHING, B_MRR_IDLE, B_MRW: if (done) st_nxt = B_IDLE;
      B_MRR_ACT: if (done) st_nxt = B_ACTIVE;
      default: st_nxt = B_IDLE;
    endcase
  end

  // State register, one per bank
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_r <= B_IDLE;
      tmr_r <= TMR_ZERO;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> tb/hst_dev_model.sv
// Device model: open rows per bank, masked write storage, read data return
`timescale 1ns/1ps
`default_nettype none
module hst_dev_model import hst_pkg::*; #(
  parameter logic [DQ_W-1:0] RD_PAT = 16'h5a3c // Word returned on reads
) (
  input wire logic clock, // System clock
  input wire logic mem_ck, // Link clock
  input wire logic mem_cke, // Clock gate
  input wire hst_cmd_t mem_cmd, // Command pins
  input wire logic [BANK_W-1:0] mem_bank, // Bank pins
  input wire logic mem_all, // All-bank flag
  input wire logic mem_auto_close, // Auto close pin
  input wire logic [DQ_W-1:0] mem_dq_o, // Write data
  input wire logic [DM_W-1:0] write_mask_pin, // Write mask
  output var logic [DQ_W-1:0] mem_dq_i, // Data back to host
  output var logic [DQ_W-1:0] stored, // Word kept by writes
  output var int dev_errs // Illegal commands seen
);
  logic [NBANK-1:0] open_r;
  logic ck_q;
  logic cke_q;
  logic live;
  int rd_cnt;
  initial begin
    open_r = '0;
    ck_q = 1'b0;
    cke_q = 1'b1;
    live = 1'b0;
    rd_cnt = 0;
    mem_dq_i = 16'h0000;
    stored = 16'h0000;
    dev_errs = 0;
  end
  // Commands are decoded at each rising link clock; a released bus toggles
  // every cycle, so after a read a late capture shows the read word on alternate cycles
  always @(posedge clock) begin
    ck_q <= mem_ck;
    if (rd_cnt > 0) rd_cnt <= rd_cnt - 1;
    mem_dq_i <= (rd_cnt > 0) ? RD_PAT : ~mem_dq_i;
    if (mem_ck && !ck_q) cke_q <= mem_cke;
    if (mem_ck && !ck_q && mem_cke && cke_q && mem_cmd != C_NOP) begin
      if (!live && !(mem_cmd == C_MRW && mem_all)) dev_errs <= dev_errs + 1;
      case (mem_cmd)
        C_ACT: begin
          if (open_r[mem_bank]) dev_errs <= dev_errs + 1;
          open_r[mem_bank] <= 1'b1;
        end
        C_RD, C_WR: begin
          if (!open_r[mem_bank]) dev_errs <= dev_errs + 1;
          if (mem_auto_close) open_r[mem_bank] <= 1'b0;
          if (mem_cmd == C_RD) rd_cnt <= 16;
          for (int i = 0; i < DM_W; i++) begin
            if (mem_cmd == C_WR && !write_mask_pin[i]) stored[i*8+:8] <= mem_dq_o[i*8+:8];
          end
        end
        C_BST: rd_cnt <= 0;
        C_PRE: begin
          if (mem_all) open_r <= '0;
          else open_r[mem_bank] <= 1'b0;
        end
        C_MRR: ;
        C_MRW, C_REF, C_SREF: begin
          if (open_r != '0) dev_errs <= dev_errs + 1;
          if (mem_cmd == C_MRW && mem_all) live <= 1'b1;
        end
        default: dev_errs <= dev_errs + 1;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/bank_command_legality_test.sv
// Testbench: legal and refused cross-bank commands through the controller
`timescale 1ns/1ps
`default_nettype none
module bank_command_legality_test import hst_pkg::*;;
  localparam logic [DQ_W-1:0] PAT = 16'h5a3c;
  logic clock, resetn, req_valid, req_all, req_auto_close, sleep_req;
  logic req_ready, req_reject, rd_valid, mem_ck, mem_cke, mem_all, mem_auto_close, mem_dq_oe;
  hst_cmd_t req_cmd, mem_cmd;
  logic [BANK_W-1:0] req_bank, mem_bank;
  logic [DQ_W-1:0] req_wdata, rd_data, mem_dq_o, mem_dq_i, stored;
  logic [DM_W-1:0] req_wmask, write_mask_pin;
  logic [1:0] res;
  int fail_count, n_checks, cyc, dev_errs;

  hst_ctrl #(.INIT_CYC(20)) uut (.clock(clock), .resetn(resetn), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_all(req_all),
    .req_auto_close(req_auto_close), .req_wdata(req_wdata), .req_wmask(req_wmask),
    .sleep_req(sleep_req), .req_ready(req_ready), .req_reject(req_reject),
    .rd_data(rd_data), .rd_valid(rd_valid), .mem_ck(mem_ck), .mem_cke(mem_cke),
    .mem_cmd(mem_cmd), .mem_bank(mem_bank), .mem_all(mem_all),
    .mem_auto_close(mem_auto_close), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe),
    .mem_dq_i(mem_dq_i), .write_mask_pin(write_mask_pin));
  hst_dev_model #(.RD_PAT(PAT)) dev (.clock(clock), .mem_ck(mem_ck), .mem_cke(mem_cke),
    .mem_cmd(mem_cmd), .mem_bank(mem_bank), .mem_all(mem_all),
    .mem_auto_close(mem_auto_close), .mem_dq_o(mem_dq_o),
    .write_mask_pin(write_mask_pin), .mem_dq_i(mem_dq_i), .stored(stored),
    .dev_errs(dev_errs));

  // Free-running 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds one request until the slot answers; res is {taken, refused}
  task automatic issue(input hst_cmd_t c, input logic [BANK_W-1:0] b, input logic a,
                       input logic ac);
    @(negedge clock);
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_all = a;
    req_auto_close = ac;
    res = 2'h0;
    for (int k = 0; k < 10 && res == 2'h0; k++) begin
      @(posedge clock);
      res = {req_ready, req_reject};
    end
    @(negedge clock);
    req_valid = 1'b0;
  endtask

  // Retries across slots while a busy period of the device runs out
  task automatic want(input hst_cmd_t c, input logic [BANK_W-1:0] b, input logic a);
    issue(c, b, a, 1'h0);
    for (int k = 0; k < 8 && res !== 2'h2; k++) issue(c, b, a, 1'h0);
  endtask

  task automatic t_reset;
    issue(C_ACT, 3'h0, 1'h0, 1'h0);
    chk(res, 2'h1);
    issue(C_RST, 3'h0, 1'h0, 1'h0);
    chk(res, 2'h2);
    chk(mem_cmd, C_MRW);
    chk(mem_all, 1'h1);
    issue(C_ACT, 3'h0, 1'h0, 1'h0);
    chk(res, 2'h1);
    issue(C_MRR, 3'h0, 1'h0, 1'h0);
    chk(res, 2'h2);
    want(C_ACT, 3'h0, 1'h0);
    chk(res, 2'h2);
    issue(C_ACT, 3'h1, 1'h0, 1'h0);
    chk(res, 2'h2);
  endtask

  task automatic t_write;
    req_wdata = 16'h1234;
    req_wmask = 2'h2;
    issue(C_WR, 3'h0, 1'h0, 1'h0);
    chk(res, 2'h2);
    chk(mem_cmd, C_WR);
    chk(mem_dq_oe, 1'h1);
    chk(mem_dq_o, 16'h1234);
    chk(write_mask_pin, 2'h2);
    issue(C_RD, 3'h1, 1'h0, 1'h0);
    chk(res, 2'h1);
    issue(C_WR, 3'h0, 1'h0, 1'h0);
    chk(res, 2'h2);
    issue(C_BST, 3'h1, 1'h0, 1'h0);
    chk(res, 2'h1);
    issue(C_WR, 3'h0, 1'h0, 1'h0);
    issue(C_BST, 3'h0, 1'h0, 1'h0);
    chk(res, 2'h2);
    chk(stored, 16'h0034);
  endtask

  task automatic t_read;
    issue(C_RD, 3'h1, 1'h0, 1'h0);
    chk(res, 2'h2);
    issue(C_WR, 3'h0, 1'h0, 1'h0);
    chk(res, 2'h1);
    for (int k = 0; k < 30 && rd_valid !== 1'b1; k++) @(negedge clock);
    chk(rd_valid, 1'h1);
    chk(rd_data, PAT);
  endtask

  task automatic t_refresh;
    issue(C_REF, 3'h0, 1'h0, 1'h0);
    chk(res, 2'h1);
    want(C_PRE, 3'h0, 1'h1);
    chk(res, 2'h2);
    want(C_REF, 3'h0, 1'h0);
    chk(res, 2'h2);
    want(C_MRW, 3'h0, 1'h0);
    chk(res, 2'h2);
    chk(mem_all, 1'h0);
    issue(C_ACT, 3'h2, 1'h0, 1'h0);
    chk(res, 2'h2);
    issue(C_MRR, 3'h0, 1'h0, 1'h0);
    chk(res, 2'h2);
    issue(C_RD, 3'h2, 1'h0, 1'h1);
    chk(res, 2'h2);
    chk(mem_auto_close, 1'h1);
    chk(mem_bank, 3'h2);
    issue(C_ACT, 3'h4, 1'h0, 1'h0);
    chk(res, 2'h2);
  endtask

  task automatic t_sleep;
    want(C_PRE, 3'h0, 1'h1);
    chk(res, 2'h2);
    @(negedge clock);
    sleep_req = 1'b1;
    for (int k = 0; k < 20 && mem_cke !== 1'b0; k++) @(negedge clock);
    chk(mem_cke, 1'h0);
    issue(C_ACT, 3'h5, 1'h0, 1'h0);
    chk(res, 2'h1);
    sleep_req = 1'b0;
    want(C_PRE, 3'h5, 1'h0);
    chk(res, 2'h2);
    // Self refresh entry, then wake with its longer exit delay
    sleep_req = 1'b1;
    issue(C_SREF, 3'h0, 1'h0, 1'h0);
    chk(res, 2'h2);
    chk(mem_cke, 1'h0);
    sleep_req = 1'b0;
    want(C_ACT, 3'h5, 1'h0);
    chk(res, 2'h2);
    chk(mem_cke, 1'h1);
  endtask

  // Hang guard, well above the few hundred cycles the scenarios need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_cmd = C_NOP;
    req_bank = 3'h0;
    req_all = 1'b0;
    req_auto_close = 1'b0;
    req_wdata = 16'h0000;
    req_wmask = 2'h0;
    sleep_req = 1'b0;
    fail_count = 0;
    n_checks = 0;
    cyc = 0;
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    t_reset();
    t_write();
    t_read();
    t_refresh();
    t_sleep();
    chk(16'(dev_errs), 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
